// File: core/power_mode_clock_manager.sv
// Implementation choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module power_mode_clock_manager
    import pmcm_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Strap pins and real-time-clock wake
    input wire logic [MSEL_W-1:0] multiplier_select_straps,
    input wire logic bypass_strap,
    input wire logic input_divide_strap,
    input wire logic [SSEL_W-1:0] divider_strap_flags,
    input wire logic rtc_wake_async,
    // Processor core status
    input wire logic irq_pending,
    input wire logic core_idle,
    // Clock enables
    output logic core_clock,
    output logic sys_clk_en,
    output logic system_clock_out_pin,
    output logic [GATE_W-1:0] periph_clk_en,
    // PLL settings
    output logic pll_enable,
    output logic pll_bypass,
    output logic [MULT_W-1:0] pll_multiplier,
    output logic pll_input_divide,
    // Power state
    output logic deep_power_down_flag,
    output logic dma_l1_allow,
    output logic [MODE_W-1:0] op_mode
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    wb_req_t req;
    pll_control_reg_t pll_control_reg_q;
    pll_control_reg_t strap_ctl;
    logic [GATE_W-1:0] peripheral_clock_gate_reg_q;
    mode_req_t cmd_req_q;
    logic cmd_pend_q;
    op_mode_t mode_q;
    op_mode_t mode_d;
    logic cmd_taken;
    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] pins_sync;
    logic rtc_lvl;
    logic rtc_lvl_q;
    logic rtc_rise;
    logic half_q;
    logic base_tick;
    logic sys_tick;
    logic bus_hit;
    logic bus_wr;
    logic [31:0] rd_d;
    logic [31:0] ctl_new;
    logic [31:0] gate_new;

    // Byte-lane merge of a register with Wishbone write data
    function automatic logic [31:0] lane_merge(
        input logic [31:0] old,
        input logic [31:0] wdat,
        input logic [3:0] sel
    );
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old & ~m) | (wdat & m);
    endfunction

    // Multiplier select to factor, zero read as one
    function automatic logic [MULT_W-1:0] mult_of(input logic [MSEL_W-1:0] msel);
        logic [MULT_W-1:0] f;
        f = msel[MULT_W-1:0];
        return (f == 5'h00) ? MULT_MIN : f;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    assign pins_raw = {rtc_wake_async, divider_strap_flags, bypass_strap,
                       input_divide_strap, multiplier_select_straps};

    pin_sync3 #(
        .W(PIN_W)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .pin_in(pins_raw),
        .pin_out(pins_sync)
    );

    // Settled strap view as a control word
    assign strap_ctl = pins_sync[CTL_W-1:0];
    assign rtc_lvl = pins_sync[PIN_W-1];

    // Real-time-clock wake edge
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            rtc_lvl_q <= 1'b0;
        end
        else
        begin
            rtc_lvl_q <= rtc_lvl;
        end
    end

    assign rtc_rise = rtc_lvl & ~rtc_lvl_q;

    ////////////////////////////////////////////////////////////////////////////
    // Wishbone slave
    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                   sel: wb_sel_i, dat: wb_dat_i};
    assign bus_hit = req.cyc & req.stb;
    // Write lands on the edge where the master sees ack
    assign bus_wr = bus_hit & req.we & wb_ack_o;
    assign ctl_new = lane_merge({21'h0, pll_control_reg_q}, req.dat, req.sel);
    assign gate_new = lane_merge({18'h0, peripheral_clock_gate_reg_q}, req.dat, req.sel);

    // Read decode, unmapped reads as zero
    always_comb
    begin
        rd_d = 32'h0;
        if (req.adr == PLL_CONTROL_OFS)
        begin
            rd_d[CTL_W-1:0] = pll_control_reg_q;
        end
        else if (req.adr == PERIPH_GATE_OFS)
        begin
            rd_d[GATE_W-1:0] = peripheral_clock_gate_reg_q;
        end
        else if (req.adr == MODE_CMD_OFS)
        begin
            rd_d[1:0] = cmd_req_q;
            rd_d[CMD_PEND_BIT] = cmd_pend_q;
        end
        else if (req.adr == MODE_STATUS_OFS)
        begin
            rd_d[MODE_W-1:0] = mode_q;
            rd_d[STAT_DEEP_BIT] = deep_power_down_flag;
            rd_d[STAT_BYPASS_BIT] = pll_bypass;
            rd_d[STAT_PLL_EN_BIT] = pll_enable;
        end
    end

    // Ack one cycle after request, dropped the cycle after
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_ack_o <= bus_hit & ~wb_ack_o;
            if (bus_hit & ~wb_ack_o & ~req.we)
            begin
                wb_dat_o <= rd_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // PLL control register
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            pll_control_reg_q <= strap_ctl;
        end
        else if (bus_wr && req.adr == PLL_CONTROL_OFS)
        begin
            pll_control_reg_q <= ctl_new[CTL_W-1:0];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            peripheral_clock_gate_reg_q <= PERIPH_GATE_RST;
        end
        else if (bus_wr && req.adr == PERIPH_GATE_OFS)
        begin
            peripheral_clock_gate_reg_q <= gate_new[GATE_W-1:0];
        end
    end

    // mode request, write wins over take
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            cmd_req_q <= REQ_NONE;
            cmd_pend_q <= 1'b0;
        end
        else if (bus_wr && req.adr == MODE_CMD_OFS && req.sel[0])
        begin
            cmd_req_q <= mode_req_t'(req.dat[1:0]);
            cmd_pend_q <= (req.dat[1:0] != REQ_NONE);
        end
        else if (cmd_taken)
        begin
            cmd_pend_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode state machine
    always_comb
    begin
        mode_d = mode_q;
        cmd_taken = 1'b0;
        case (mode_q)
            MODE_FULL_ON, MODE_ACTIVE:
            begin
                // act only once the core is idle
                if (cmd_pend_q && core_idle)
                begin
                    cmd_taken = 1'b1;
                    case (cmd_req_q)
                        REQ_APPLY:
                            mode_d = pll_control_reg_q.bypass ? MODE_ACTIVE : MODE_FULL_ON;
                        REQ_SLEEP:
                            mode_d = MODE_SLEEP;
                        REQ_DEEP:
                            mode_d = MODE_DEEP_SLEEP;
                        default:
                            mode_d = mode_q;
                    endcase
                end
            end
            MODE_SLEEP:
            begin
                if (irq_pending)
                begin
                    mode_d = pll_control_reg_q.bypass ? MODE_ACTIVE : MODE_FULL_ON;
                end
            end
            MODE_DEEP_SLEEP:
            begin
                if (rtc_rise)
                begin
                    mode_d = MODE_FULL_ON;
                end
            end
            default:
            begin
                mode_d = MODE_FULL_ON;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            mode_q <= strap_ctl.bypass ? MODE_ACTIVE : MODE_FULL_ON;
        end
        else
        begin
            mode_q <= mode_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Base tick: every cycle unbypassed, every other cycle bypassed, none in deep sleep
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            half_q <= 1'b0;
        end
        else
        begin
            half_q <= ~half_q;
        end
    end

    assign base_tick = (mode_q == MODE_DEEP_SLEEP) ? 1'b0 : (pll_bypass ? half_q : 1'b1);

    sys_clk_divider u_sys_div (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .base_tick(base_tick),
        .ssel(pll_control_reg_q.ssel),
        .sys_tick(sys_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock enable outputs
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            core_clock <= 1'b0;
            sys_clk_en <= 1'b0;
            system_clock_out_pin <= 1'b0;
            periph_clk_en <= '0;
        end
        else
        begin
            core_clock <= base_tick & (mode_q inside {MODE_FULL_ON, MODE_ACTIVE});
            // system tick to pin and peripherals
            sys_clk_en <= sys_tick;
            system_clock_out_pin <= sys_tick;
            periph_clk_en <= sys_tick ? peripheral_clock_gate_reg_q : '0;
        end
    end

    // PLL settings and power indications
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            pll_enable <= 1'b1;
            pll_bypass <= 1'b0;
            pll_multiplier <= MULT_MIN;
            pll_input_divide <= 1'b0;
            deep_power_down_flag <= 1'b0;
            dma_l1_allow <= 1'b0;
            op_mode <= '0;
        end
        else
        begin
            pll_multiplier <= mult_of(pll_control_reg_q.msel);
            pll_input_divide <= pll_control_reg_q.in_div;
            pll_enable <= (mode_d != MODE_DEEP_SLEEP);
            if (mode_d == MODE_ACTIVE)
            begin
                pll_bypass <= 1'b1;
            end
            else if (mode_d == MODE_FULL_ON)
            begin
                pll_bypass <= 1'b0;
            end
            else if (mode_d == MODE_SLEEP)
            begin
                pll_bypass <= pll_control_reg_q.bypass;
            end
            deep_power_down_flag <= (mode_d == MODE_DEEP_SLEEP);
            dma_l1_allow <= (mode_d == MODE_FULL_ON) | (mode_d == MODE_ACTIVE);
            op_mode <= mode_d;
        end
    end

endmodule // power_mode_clock_manager
`default_nettype wire

// File: include/pmcm_pkg.sv
// Shared constants and types of the power-mode clock manager
package pmcm_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets on the Wishbone bus (byte addresses)
    localparam logic [7:0] PLL_CONTROL_OFS = 8'h00;
    localparam logic [7:0] PERIPH_GATE_OFS = 8'h04;
    localparam logic [7:0] MODE_CMD_OFS = 8'h08;
    localparam logic [7:0] MODE_STATUS_OFS = 8'h0c;

    // Field widths and positions
    localparam int MSEL_W = 7;
    localparam int MULT_W = 5;
    localparam int SSEL_W = 2;
    localparam int GATE_W = 14;
    localparam int MODE_W = 4;
    localparam int CMD_PEND_BIT = 4;
    localparam int STAT_DEEP_BIT = 4;
    localparam int STAT_BYPASS_BIT = 5;
    localparam int STAT_PLL_EN_BIT = 6;
    localparam int CTL_W = 11;

    // Reset values
    localparam logic [GATE_W-1:0] PERIPH_GATE_RST = 14'h3fff;
    localparam logic [MULT_W-1:0] MULT_MIN = 5'h01;

    // System divider thresholds, in half core-clock ticks
    localparam logic [3:0] HALF_STEP = 4'h2;
    localparam logic [3:0] THR_2_0 = 4'h4;
    localparam logic [3:0] THR_2_5 = 4'h5;
    localparam logic [3:0] THR_3_0 = 4'h6;
    localparam logic [3:0] THR_4_0 = 4'h8;

    // Number of synchronised pins: 7 msel, bypass, divide, 2 flags, rtc
    localparam int PIN_W = 12;

    ////////////////////////////////////////////////////////////////////////////
    // Operating modes, one-hot
    typedef enum logic [MODE_W-1:0] {
        MODE_FULL_ON = 4'h1,
        MODE_ACTIVE = 4'h2,
        MODE_SLEEP = 4'h4,
        MODE_DEEP_SLEEP = 4'h8
    } op_mode_t;

    // Software mode requests
    typedef enum logic [1:0] {
        REQ_APPLY = 2'h0,
        REQ_SLEEP = 2'h1,
        REQ_DEEP = 2'h2,
        REQ_NONE = 2'h3
    } mode_req_t;

    // Contents of the PLL control register
    typedef struct packed {
        logic [SSEL_W-1:0] ssel;
        logic bypass;
        logic in_div;
        logic [MSEL_W-1:0] msel;
    } pll_control_reg_t;

    // Wishbone request carrier
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } wb_req_t;

endpackage

// File: core/pin_sync3.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; output moves once stages two and three agree
module pin_sync3
    import pmcm_pkg::*;
#(
    parameter int W = 1
)
(
    // Clock
    input wire logic ref_clk,
    // Raw pins and settled result
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out
);

    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            // Chain and agreement filter per bit
            always_ff @(posedge ref_clk)
            begin
                s1_q[i] <= pin_in[i];
                s2_q[i] <= s1_q[i];
                s3_q[i] <= s2_q[i];
                if (s2_q[i] == s3_q[i])
                begin
                    pin_out[i] <= s3_q[i];
                end
            end
        end
    endgenerate

endmodule // pin_sync3
`default_nettype wire

// File: core/sys_clk_divider.sv
`timescale 1ns/1ps
`default_nettype none
// Core-to-system tick divider: 2, 2.5, 3 or 4 base ticks per system tick
module sys_clk_divider
    import pmcm_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Base tick and ratio select
    input wire logic base_tick,
    input wire logic [SSEL_W-1:0] ssel,
    // One-cycle system tick
    output logic sys_tick
);

    logic [3:0] acc_q;
    logic [3:0] thr;
    logic [3:0] sum;

    // Ratio select to half-tick threshold
    always_comb
    begin
        case (ssel)
            2'h0: thr = THR_2_0;
            2'h1: thr = THR_2_5;
            2'h2: thr = THR_3_0;
            default: thr = THR_4_0;
        endcase
        sum = acc_q + HALF_STEP;
    end

    // Fractional accumulator
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            acc_q <= 4'h0;
            sys_tick <= 1'b0;
        end
        else if (base_tick)
        begin
            if (sum >= thr)
            begin
                acc_q <= sum - thr;
                sys_tick <= 1'b1;
            end
            else
            begin
                acc_q <= sum;
                sys_tick <= 1'b0;
            end
        end
        else
        begin
            sys_tick <= 1'b0;
        end
    end

endmodule // sys_clk_divider
`default_nettype wire

// File: verif/pmcm_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Timing checks on the manager's clock enables and mode outputs
module pmcm_checker
    import pmcm_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Bus and core status
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic irq_pending,
    // Clock enables
    input wire logic core_clock,
    input wire logic sys_clk_en,
    input wire logic system_clock_out_pin,
    input wire logic [GATE_W-1:0] periph_clk_en,
    // PLL and power state
    input wire logic pll_enable,
    input wire logic pll_bypass,
    input wire logic deep_power_down_flag,
    input wire logic dma_l1_allow,
    input wire logic [MODE_W-1:0] op_mode
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    logic [MODE_W-1:0] m1_q;
    logic [MODE_W-1:0] m2_q;
    logic [MODE_W-1:0] m3_q;
    logic held;

    // Mode history, lets tick outputs settle
    always_ff @(posedge ref_clk)
    begin
        m1_q <= op_mode;
        m2_q <= m1_q;
        m3_q <= m2_q;
    end
    assign held = (op_mode == m1_q) && (m1_q == m2_q) && (m2_q == m3_q);

    ////////////////////////////////////////////////////////////////////////////
    AST_SLEEP_CORE:
        assert property (held && op_mode == MODE_SLEEP |-> !core_clock && pll_enable)
        else $error("core tick while sleeping");
    AST_SLEEP_WAKE:
        assert property (op_mode == MODE_SLEEP && irq_pending
            |=> op_mode == ($past(pll_bypass) ? MODE_ACTIVE : MODE_FULL_ON))
        else $error("wrong wake from sleep");
    AST_DMA_ALLOW:
        assert property (dma_l1_allow == (op_mode == MODE_FULL_ON || op_mode == MODE_ACTIVE))
        else $error("dma allow does not match mode");
    AST_DEEP_CLOCKS:
        assert property (op_mode == MODE_DEEP_SLEEP |-> !pll_enable ##0
            (!held || (!core_clock && !sys_clk_en)))
        else $error("clock running in deep sleep");
    AST_DEEP_FLAG:
        assert property (deep_power_down_flag == (op_mode == MODE_DEEP_SLEEP))
        else $error("deep flag does not match mode");
    AST_FULL_ON:
        assert property (held && op_mode == MODE_FULL_ON |-> pll_enable && !pll_bypass
            && core_clock)
        else $error("full on clocking wrong");
    AST_ACTIVE_HALF:
        assert property (held && op_mode == MODE_ACTIVE |-> core_clock != $past(core_clock))
        else $error("active core tick not every second cycle");
    AST_PERIPH_GATE:
        assert property (|periph_clk_en |-> sys_clk_en)
        else $error("peripheral tick without system tick");
    AST_CLK_PIN:
        assert property (system_clock_out_pin == sys_clk_en)
        else $error("clock pin differs from system tick");
    AST_WB_ACK:
        assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single pulse");
endmodule // pmcm_checker

bind power_mode_clock_manager pmcm_checker u_pmcm_checker (
    .ref_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .irq_pending,
    .core_clock, .sys_clk_en, .system_clock_out_pin, .periph_clk_en,
    .pll_enable, .pll_bypass, .deep_power_down_flag, .dma_l1_allow, .op_mode
);
`default_nettype wire

// File: verif/core_model.sv
`timescale 1ns/1ps
`default_nettype none
// Processor core stand-in: idle handshake and interrupt line
module core_model
    import pmcm_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Bench requests
    input wire logic idle_req,
    input wire logic wake_req,
    // Core status to the manager
    output logic core_idle,
    output logic irq_pending
);
    always_ff @(posedge ref_clk)
    begin
        core_idle <= resetn && idle_req;
    end

    // interrupts masked while idle, no DMA issued
    always_ff @(posedge ref_clk)
    begin
        irq_pending <= resetn && wake_req && !idle_req;
    end
endmodule // core_model
`default_nettype wire

// File: verif/power_mode_clock_manager_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Bench for the power-mode clock manager
module power_mode_clock_manager_tb_top
    import pmcm_pkg::*;
;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    wb_req_t req = '0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [MSEL_W-1:0] msel_s = 7'h05;
    logic bypass_s = 1'b1;
    logic div_s = 1'b1;
    logic [SSEL_W-1:0] flags_s = 2'h2;
    logic rtc = 1'b0;
    logic wake_req = 1'b0;
    logic idle_req = 1'b0;
    logic irq_pending, core_idle, core_clock, sys_clk_en, pin_clk;
    logic pll_enable, pll_bypass, pll_input_divide, deep_power_down_flag, dma_l1_allow;
    logic [GATE_W-1:0] periph_clk_en;
    logic [MULT_W-1:0] pll_multiplier;
    logic [MODE_W-1:0] op_mode;
    logic [31:0] exp_q[$];
    logic [3:0] thr [4] = '{THR_2_0, THR_2_5, THR_3_0, THR_4_0};
    int num_errors = 0;
    int total_checks = 0;

    // 50 MHz clock
    always #10 ref_clk = ~ref_clk;

    power_mode_clock_manager u_power_mode_clock_manager (
        .ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
        .wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .multiplier_select_straps(msel_s),
        .bypass_strap(bypass_s), .input_divide_strap(div_s), .divider_strap_flags(flags_s),
        .rtc_wake_async(rtc), .irq_pending(irq_pending), .core_idle(core_idle),
        .core_clock(core_clock), .sys_clk_en(sys_clk_en), .system_clock_out_pin(pin_clk),
        .periph_clk_en(periph_clk_en), .pll_enable(pll_enable), .pll_bypass(pll_bypass),
        .pll_multiplier(pll_multiplier), .pll_input_divide(pll_input_divide),
        .deep_power_down_flag(deep_power_down_flag), .dma_l1_allow(dma_l1_allow),
        .op_mode(op_mode)
    );

    core_model u_core_model (
        .ref_clk(ref_clk), .resetn(resetn), .idle_req(idle_req), .wake_req(wake_req),
        .core_idle(core_idle), .irq_pending(irq_pending)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Single compare
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Classic Wishbone cycle, held until ack
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n = 0;
        @(posedge ref_clk);
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 50);
        req.cyc <= 1'b0;
        req.stb <= 1'b0;
        if (n >= 50)
        begin
            num_errors++;
            report_and_stop();
        end
    endtask

    // Read with expected value noted
    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        exp_q.push_back(exp);
        wb(1'b0, adr, 32'h0);
    endtask

    // Mode request with core held idle
    task automatic mode_cmd(input mode_req_t c);
        @(posedge ref_clk);
        idle_req <= 1'b1;
        wb(1'b1, MODE_CMD_OFS, {30'h0, c});
    endtask

    // Bounded wait for a mode, then compare
    task automatic wait_mode(input op_mode_t m);
        int n = 0;
        while (op_mode !== m && n < 30)
        begin
            @(posedge ref_clk);
            n++;
        end
        chk(op_mode, m);
        idle_req <= 1'b0;
        if (n >= 30)
        begin
            num_errors++;
            report_and_stop();
        end
    endtask

    // Tick counts over a window
    task automatic count(input int cyc, output int nc, output int ns);
        nc = 0;
        ns = 0;
        repeat (cyc)
        begin
            @(posedge ref_clk);
            nc += (core_clock === 1'b1);
            ns += (sys_clk_en === 1'b1);
        end
    endtask

    // Read data compare on each read ack
    always @(posedge ref_clk)
    begin
        if (wb_ack_o === 1'b1 && req.we === 1'b0 && exp_q.size() > 0)
            chk(wb_dat_o, exp_q.pop_front());
    end

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        int nc, ns, seed;
        logic [6:0] m;
        logic [13:0] g;
        seed = $urandom(32'h5595);
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        rd(PLL_CONTROL_OFS, 32'h585);
        rd(PERIPH_GATE_OFS, {18'h0, PERIPH_GATE_RST});
        rd(MODE_STATUS_OFS, 32'h62);
        rd(8'h10, 32'h0);
        chk(pll_multiplier, 5'h05);
        chk(pll_input_divide, 1'b1);
        count(40, nc, ns);
        chk(nc, 20);
        $display("test strap_reset done");
        m = 7'($urandom_range(31, 1));
        wb(1'b1, PLL_CONTROL_OFS, {21'h0, 4'h0, m});
        mode_cmd(REQ_APPLY);
        wait_mode(MODE_FULL_ON);
        chk(pll_multiplier, m[4:0]);
        chk(pll_input_divide, 1'b0);
        rd(MODE_STATUS_OFS, 32'h41);
        mode_cmd(REQ_NONE);
        rd(MODE_CMD_OFS, 32'h3);
        wait_mode(MODE_FULL_ON);
        // every ratio gives its expected system tick count over 80 cycles
        for (int s = 0; s < 4; s++)
        begin
            wb(1'b1, PLL_CONTROL_OFS, {21'h0, 2'(s), 2'h0, m});
            rd(PLL_CONTROL_OFS, {21'h0, 2'(s), 2'h0, m});
            count(80, nc, ns);
            chk(32'(ns * thr[s] >= 160 - thr[s] && ns * thr[s] <= 160 + thr[s]), 1);
            chk(nc, 80);
        end
        $display("test ratios done");
        g = 14'($urandom);
        wb(1'b1, PERIPH_GATE_OFS, {18'h0, g});
        rd(PERIPH_GATE_OFS, {18'h0, g});
        repeat (24)
        begin
            @(posedge ref_clk);
            chk(periph_clk_en, sys_clk_en ? g : 14'h0);
        end
        $display("test gates done");
        for (int b = 0; b < 2; b++)
        begin
            wb(1'b1, PLL_CONTROL_OFS, {21'h0, 2'h0, 1'(b), 1'b0, m});
            mode_cmd(REQ_SLEEP);
            wait_mode(MODE_SLEEP);
            rd(MODE_STATUS_OFS, {25'h0, 1'b1, 1'(b), 5'h04});
            count(40, nc, ns);
            chk(nc, 0);
            chk(32'(ns > 0), 1);
            chk(dma_l1_allow, 1'b0);
            wake_req <= 1'b1;
            wait_mode(b ? MODE_ACTIVE : MODE_FULL_ON);
            wake_req <= 1'b0;
            chk(dma_l1_allow, 1'b1);
        end
        $display("test sleep done");
        mode_cmd(REQ_DEEP);
        wait_mode(MODE_DEEP_SLEEP);
        chk(deep_power_down_flag, 1'b1);
        // Let the tick pipeline drain
        repeat (2) @(posedge ref_clk);
        wake_req <= 1'b1;
        count(40, nc, ns);
        chk(nc + ns, 0);
        chk(op_mode, MODE_DEEP_SLEEP);
        wake_req <= 1'b0;
        rtc <= 1'b1;
        wait_mode(MODE_FULL_ON);
        rtc <= 1'b0;
        chk(deep_power_down_flag, 1'b0);
        $display("test deep_rtc done");
        mode_cmd(REQ_DEEP);
        wait_mode(MODE_DEEP_SLEEP);
        bypass_s <= 1'b0;
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        wait_mode(MODE_FULL_ON);
        rd(PLL_CONTROL_OFS, 32'h485);
        $display("test deep_reset done");
        report_and_stop();
    end
endmodule // power_mode_clock_manager_tb_top
`default_nettype wire
